/* File: core/tro_unit.sv */
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/100ps
module tro_unit
    import tro_pkg::*;
#(
    parameter int WB_AW = 4
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic start,
    input wire logic [15:0] instr,
    input wire logic [15:0] pc_in,
    input wire logic [15:0] sp_in,
    input wire logic [15:0] ps_in,
    input wire logic [15:0] ea_in,
    input wire logic ea_is_reg,
    input wire logic [15:0] reg_val_in,
    output logic busy,
    output logic done,
    output logic [15:0] pc_out,
    output logic [15:0] sp_out,
    output logic [15:0] ps_out,
    output logic reg_wr,
    output logic [15:0] reg_wr_data,
    output logic trace_trap,
    output logic illegal,
    output logic mem_req,
    output logic mem_we,
    output logic mem_byte,
    output logic [1:0] mem_space,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack,
    output logic bus_abort,
    output logic bus_init,
    input wire logic continue_key,
    output logic halted,
    output logic resume,
    output logic [15:0] console_data
);
    import tro_pkg::*;

    // Refuses an address width that cannot reach the register map.
    if (WB_AW < 4) begin : g_aw_check
        $error("WB_AW too small for the register map.");
    end

    typedef enum logic [3:0] {
        ST_IDLE, ST_PUSH_PS, ST_PUSH_PC, ST_VEC_PC, ST_VEC_PS, ST_POP_PC,
        ST_POP_PS, ST_SRC_RD, ST_PUSH_W, ST_MTP_POP, ST_DST_WR, ST_FINISH,
        ST_HALTED
    } tro_state_e;

    function automatic tro_op_e tro_decode(input logic [15:0] op);
        tro_op_e k;
        k = TRO_NONE;
        if (op >= EMT_LO && op <= EMT_HI) begin
            k = TRO_EMT;
        end else if (op >= SWT_LO && op <= SWT_HI) begin
            k = TRO_SWT;
        end else if (op == OP_IRET) begin
            k = TRO_IRET;
        end else if (op == OP_RTT) begin
            k = TRO_RTT;
        end else if (op == OP_STOP) begin
            k = TRO_STOP;
        end else if (op[14:6] == OP_MFP_HI) begin
            k = TRO_MFP;
        end else if (op[14:6] == OP_MTP_HI) begin
            k = TRO_MTP;
        end else if (op[15:6] == OP_READ_STATUS_BYTE_HI) begin
            k = TRO_READ_STATUS_BYTE;
        end else if (op[15:6] == OP_WRITE_STATUS_BYTE_HI) begin
            k = TRO_WRITE_STATUS_BYTE;
        end
        return k;
    endfunction

    tro_state_e state_q;
    tro_op_e kind_q;
    logic [15:0] sp_q;
    logic [15:0] ps_q;
    logic [15:0] pc_q;
    logic [15:0] ea_q;
    logic [15:0] vec_q;
    logic [15:0] tmp_q;
    logic dst_reg_q;
    logic cont_req_q;
    logic m_act;
    logic m_we;
    logic m_byte;
    logic [1:0] m_space;
    logic [15:0] m_addr;
    logic [15:0] m_wdata;
    tro_op_e dec_k;
    logic [7:0] ps_lo_new;

    assign dec_k = tro_decode(instr);
    // Trace flag is kept from the old status, the rest is the source byte.
    assign ps_lo_new = {tmp_q[7:5], ps_q[PS_T], tmp_q[3:0]};

    always_comb begin
        m_act = 1'b1;
        m_we = 1'b0;
        m_byte = 1'b0;
        m_space = ps_q[PS_CUR_HI:PS_CUR_LO];
        m_addr = sp_q;
        m_wdata = tmp_q;
        unique case (state_q)
            ST_PUSH_PS: begin
                m_we = 1'b1;
                m_addr = sp_q - WORD_STEP;
                m_wdata = ps_q;
            end
            ST_PUSH_PC, ST_PUSH_W: begin
                m_we = 1'b1;
                m_addr = sp_q - WORD_STEP;
                m_wdata = (state_q == ST_PUSH_PC) ? pc_q : tmp_q;
            end
            ST_VEC_PC: begin
                m_space = SPACE_KERNEL;
                m_addr = vec_q;
            end
            ST_VEC_PS: begin
                m_space = SPACE_KERNEL;
                m_addr = vec_q + VEC_PS_OFS;
            end
            ST_POP_PC, ST_POP_PS, ST_MTP_POP: begin
                m_addr = sp_q;
            end
            ST_SRC_RD: begin
                m_byte = (kind_q == TRO_WRITE_STATUS_BYTE);
                m_addr = ea_q;
                if (kind_q == TRO_MFP) begin
                    m_space = ps_q[PS_PRV_HI:PS_PRV_LO];
                end
            end
            ST_DST_WR: begin
                m_we = 1'b1;
                m_addr = ea_q;
                m_byte = (kind_q == TRO_READ_STATUS_BYTE);
                if (kind_q == TRO_MTP) begin
                    m_space = ps_q[PS_PRV_HI:PS_PRV_LO];
                end
            end
            default: begin
                m_act = 1'b0;
            end
        endcase
    end

    // Memory request is held until acknowledged, then dropped.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_byte <= 1'b0;
            mem_space <= SPACE_KERNEL;
            mem_addr <= RESET_WORD[15:0];
            mem_wdata <= RESET_WORD[15:0];
        end else if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
        end else if (m_act && !mem_req) begin
            mem_req <= 1'b1;
            mem_we <= m_we;
            mem_byte <= m_byte;
            mem_space <= m_space;
            mem_addr <= m_addr;
            mem_wdata <= m_wdata;
        end
    end

    logic acked;
    assign acked = mem_req && mem_ack;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            kind_q <= TRO_NONE;
            sp_q <= RESET_WORD[15:0];
            ps_q <= RESET_WORD[15:0];
            pc_q <= RESET_WORD[15:0];
            ea_q <= RESET_WORD[15:0];
            vec_q <= RESET_WORD[15:0];
            tmp_q <= RESET_WORD[15:0];
            dst_reg_q <= 1'b0;
            done <= 1'b0;
            reg_wr <= 1'b0;
            reg_wr_data <= RESET_WORD[15:0];
            trace_trap <= 1'b0;
            illegal <= 1'b0;
            bus_abort <= 1'b0;
            halted <= 1'b0;
            resume <= 1'b0;
            console_data <= RESET_WORD[15:0];
        end else begin
            done <= 1'b0;
            reg_wr <= 1'b0;
            trace_trap <= 1'b0;
            bus_abort <= 1'b0;
            resume <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        kind_q <= dec_k;
                        sp_q <= sp_in;
                        ps_q <= ps_in;
                        pc_q <= pc_in;
                        ea_q <= ea_in;
                        dst_reg_q <= ea_is_reg;
                        tmp_q <= reg_val_in;
                        illegal <= (dec_k == TRO_NONE);
                        vec_q <= (dec_k == TRO_EMT) ? EMT_VEC : SWT_VEC;
                        unique case (dec_k)
                            TRO_EMT, TRO_SWT: begin
                                state_q <= ST_PUSH_PS;
                            end
                            TRO_IRET, TRO_RTT: begin
                                state_q <= ST_POP_PC;
                            end
                            TRO_MFP, TRO_WRITE_STATUS_BYTE: begin
                                // No mode check on status moves.
                                state_q <= ea_is_reg ? ST_FINISH : ST_SRC_RD;
                                if (ea_is_reg && dec_k == TRO_MFP) begin
                                    state_q <= ST_PUSH_W;
                                end
                            end
                            TRO_MTP: begin
                                state_q <= ST_MTP_POP;
                            end
                            TRO_READ_STATUS_BYTE: begin
                                tmp_q <= {8'h00, ps_in[7:0]};
                                state_q <= ea_is_reg ? ST_FINISH : ST_DST_WR;
                            end
                            TRO_STOP: begin
                                // PC already points past the stop.
                                halted <= 1'b1;
                                console_data <= pc_in;
                                bus_abort <= 1'b1;
                                state_q <= ST_HALTED;
                            end
                            default: begin
                                state_q <= ST_FINISH;
                            end
                        endcase
                    end
                end
                ST_PUSH_PS, ST_PUSH_PC, ST_PUSH_W: begin
                    if (acked) begin
                        sp_q <= sp_q - WORD_STEP;
                        if (state_q == ST_PUSH_PS) begin
                            state_q <= ST_PUSH_PC;
                        end else if (state_q == ST_PUSH_PC) begin
                            state_q <= ST_VEC_PC;
                        end else begin
                            state_q <= ST_FINISH;
                        end
                    end
                end
                ST_VEC_PC: begin
                    if (acked) begin
                        pc_q <= mem_rdata;
                        state_q <= ST_VEC_PS;
                    end
                end
                ST_VEC_PS: begin
                    if (acked) begin
                        ps_q <= mem_rdata;
                        state_q <= ST_FINISH;
                    end
                end
                ST_POP_PC, ST_POP_PS, ST_MTP_POP: begin
                    if (acked) begin
                        sp_q <= sp_q + WORD_STEP;
                        if (state_q == ST_POP_PC) begin
                            pc_q <= mem_rdata;
                            state_q <= ST_POP_PS;
                        end else if (state_q == ST_POP_PS) begin
                            ps_q <= mem_rdata;
                            state_q <= ST_FINISH;
                        end else begin
                            tmp_q <= mem_rdata;
                            state_q <= dst_reg_q ? ST_FINISH : ST_DST_WR;
                        end
                    end
                end
                ST_SRC_RD: begin
                    if (acked) begin
                        tmp_q <= mem_rdata;
                        state_q <= (kind_q == TRO_MFP) ? ST_PUSH_W : ST_FINISH;
                    end
                end
                ST_DST_WR: begin
                    if (acked) begin
                        state_q <= ST_FINISH;
                    end
                end
                ST_FINISH: begin
                    done <= 1'b1;
                    state_q <= ST_IDLE;
                    unique case (kind_q)
                        TRO_IRET: begin
                            trace_trap <= ps_q[PS_T];
                        end
                        TRO_MFP, TRO_MTP: begin
                            ps_q[PS_N] <= tmp_q[15];
                            ps_q[PS_Z] <= (tmp_q == 16'h0000);
                            ps_q[PS_V] <= 1'b0;
                            reg_wr <= (kind_q == TRO_MTP) && dst_reg_q;
                            reg_wr_data <= tmp_q;
                        end
                        TRO_READ_STATUS_BYTE: begin
                            ps_q[PS_N] <= ps_q[PS_SIGN];
                            ps_q[PS_Z] <= (ps_q[7:0] == 8'h00);
                            ps_q[PS_V] <= 1'b0;
                            reg_wr <= dst_reg_q;
                            reg_wr_data <= {{8{ps_q[PS_SIGN]}}, ps_q[7:0]};
                        end
                        TRO_WRITE_STATUS_BYTE: begin
                            ps_q[7:0] <= ps_lo_new;
                        end
                        default: begin
                        end
                    endcase
                end
                ST_HALTED: begin
                    if (continue_key || cont_req_q) begin
                        halted <= 1'b0;
                        resume <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign busy = (state_q != ST_IDLE);
    assign pc_out = pc_q;
    assign sp_out = sp_q;
    assign ps_out = ps_q;

    // Bus initialize is held low; this block never asserts it.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bus_init <= 1'b0;
        end else begin
            bus_init <= 1'b0;
        end
    end

    // Wishbone slave: one wait state, unmapped reads give zero.
    logic wb_hit;
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= RESET_WORD;
            cont_req_q <= 1'b0;
        end else begin
            wb_ack_o <= wb_hit;
            cont_req_q <= 1'b0;
            if (wb_hit && wb_we_i && wb_sel_i[0]
                    && wb_adr_i[3:0] == REG_CONTROL) begin
                cont_req_q <= wb_dat_i[CTL_CONT_BIT];
            end
            wb_dat_o <= RESET_WORD;
            if (wb_hit && !wb_we_i) begin
                unique case (wb_adr_i[3:0])
                    REG_STATUS: begin
                        wb_dat_o[ST_HALTED_BIT] <= halted;
                        wb_dat_o[ST_BUSY_BIT] <= busy;
                        wb_dat_o[ST_ILLEGAL_BIT] <= illegal;
                    end
                    REG_CONSOLE: begin
                        wb_dat_o[15:0] <= console_data;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    a_emt_vector: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (mem_req && state_q == ST_VEC_PC && kind_q == TRO_EMT)
        |-> mem_addr == EMT_VEC) else $error("Bad emulator vector.");
    a_swt_vector: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (mem_req && state_q == ST_VEC_PS && kind_q == TRO_SWT)
        |-> mem_addr == SWT_VEC + VEC_PS_OFS) else $error("Bad vector.");
    a_vec_flags: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_q == ST_VEC_PS && acked) |=> ps_q == $past(mem_rdata))
        else $error("Status not loaded from vector.");
    a_iret_trace: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_q == ST_FINISH && kind_q == TRO_IRET && ps_q[PS_T])
        |=> trace_trap && done) else $error("Missing trace trap.");
    a_rtt_no_trace: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_q == ST_FINISH && kind_q == TRO_RTT) |=> !trace_trap)
        else $error("Trace trap not deferred.");
    a_push_predec: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (acked && mem_we && state_q == ST_PUSH_PS)
        |=> sp_q == $past(mem_addr)) else $error("Bad push.");
    a_write_status_byte_trace: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_q == ST_FINISH && kind_q == TRO_WRITE_STATUS_BYTE)
        |=> $stable(ps_q[PS_T])) else $error("Trace flag moved.");
    a_read_status_byte_sext: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (reg_wr && kind_q == TRO_READ_STATUS_BYTE)
        |-> reg_wr_data[15:8] == {8{reg_wr_data[7]}})
        else $error("No sign extension.");
    a_stop_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
        halted |-> !mem_req && !bus_init)
        else $error("Bus active while stopped.");
    a_wb_ack_drop: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wb_ack_o |=> !wb_ack_o) else $error("Ack held two cycles.");

    c_emt_done: cover property (@(posedge clk_sys) disable iff (!reset_n)
        done && kind_q == TRO_EMT);
    c_iret_trace: cover property (@(posedge clk_sys) disable iff (!reset_n)
        trace_trap);
    c_halt_resume: cover property (@(posedge clk_sys) disable iff (!reset_n)
        resume);
    c_mtp_mem: cover property (@(posedge clk_sys) disable iff (!reset_n)
        done && kind_q == TRO_MTP && !dst_reg_q);

endmodule

/* File: core/tro_pkg.sv */
package tro_pkg;

    // Trap vectors: new program counter word, then status word.
    localparam logic [15:0] EMT_VEC = 16'h0018;
    localparam logic [15:0] SWT_VEC = 16'h001c;
    localparam logic [15:0] VEC_PS_OFS = 16'h0002;
    localparam logic [15:0] WORD_STEP = 16'h0002;

    // Opcode boundaries and fixed opcodes.
    localparam logic [15:0] EMT_LO = 16'h8800;
    localparam logic [15:0] EMT_HI = 16'h88ff;
    localparam logic [15:0] SWT_LO = 16'h8900;
    localparam logic [15:0] SWT_HI = 16'h89ff;
    localparam logic [15:0] OP_STOP = 16'h0000;
    localparam logic [15:0] OP_IRET = 16'h0002;
    localparam logic [15:0] OP_RTT = 16'h0006;
    localparam logic [8:0] OP_MFP_HI = 9'h035;
    localparam logic [8:0] OP_MTP_HI = 9'h036;
    localparam logic [9:0] OP_WRITE_STATUS_BYTE_HI = 10'h234;
    localparam logic [9:0] OP_READ_STATUS_BYTE_HI = 10'h237;

    // Status word fields.
    localparam int PS_N = 3;
    localparam int PS_Z = 2;
    localparam int PS_V = 1;
    localparam int PS_C = 0;
    localparam int PS_T = 4;
    localparam int PS_SIGN = 7;
    localparam int PS_CUR_HI = 15;
    localparam int PS_CUR_LO = 14;
    localparam int PS_PRV_HI = 13;
    localparam int PS_PRV_LO = 12;
    localparam logic [1:0] SPACE_KERNEL = 2'h0;

    // Wishbone register map and fields.
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_CONTROL = 4'h4;
    localparam logic [3:0] REG_CONSOLE = 4'h8;
    localparam int ST_HALTED_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_ILLEGAL_BIT = 2;
    localparam int CTL_CONT_BIT = 0;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef enum logic [3:0] {
        TRO_NONE, TRO_EMT, TRO_SWT, TRO_IRET, TRO_RTT, TRO_MFP, TRO_MTP,
        TRO_READ_STATUS_BYTE, TRO_WRITE_STATUS_BYTE, TRO_STOP
    } tro_op_e;

endpackage

/* File: verif/tro_mem_model.sv */
`timescale 1ns/100ps
module tro_mem_model (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic [1:0] lag,
    output logic [15:0] mem_rdata,
    output logic mem_ack
);
    logic [15:0] mem [0:255];
    logic [1:0] wait_q;
    // Answers after lag idle cycles; read data toggles when not valid.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wait_q <= 2'h0;
            mem_ack <= 1'b0;
            mem_rdata <= 16'h5a5a;
        end else if (mem_req && !mem_ack && wait_q >= lag) begin
            wait_q <= 2'h0;
            mem_ack <= 1'b1;
            if (mem_we) begin
                mem[mem_addr[8:1]] <= mem_wdata;
            end else begin
                mem_rdata <= mem[mem_addr[8:1]];
            end
        end else begin
            wait_q <= (mem_req && !mem_ack) ? wait_q + 2'h1 : 2'h0;
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

/* File: verif/tro_unit_tb.sv */
`timescale 1ns/100ps
module tro_unit_tb;
    import tro_pkg::*;
    logic clk_sys = 1'b0, reset_n = 1'b0, cyc = 1'b0, we = 1'b0;
    logic start = 1'b0, ea_is_reg = 1'b0, continue_key = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, wb_dat_o;
    logic [15:0] instr = 16'h0, pc_in = 16'h0, sp_in = 16'h0, ps_in = 16'h0;
    logic [15:0] ea_in = 16'h0, reg_val_in = 16'h0, pc_out, sp_out, ps_out;
    logic [15:0] reg_wr_data, mem_addr, mem_wdata, mem_rdata, console_data;
    logic [15:0] wr_data;
    logic wb_ack_o, busy, done, reg_wr, trace_trap, illegal, mem_req, mem_we;
    logic mem_byte, mem_ack, bus_abort, bus_init, halted, resume, trc;
    logic wr, rd_byte;
    logic [1:0] mem_space, lag = 2'h0, rd_space, wr_space;
    int n_mismatch = 0, compares = 0, cycles = 0, n_resume = 0, n0;
    int n_abort = 0;
    always #12.5 clk_sys = ~clk_sys;
    tro_mem_model mem_m (.clk_sys, .reset_n, .mem_req, .mem_we, .mem_addr,
        .mem_wdata, .lag, .mem_rdata, .mem_ack);
    tro_unit uut (.clk_sys, .reset_n, .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o, .wb_ack_o, .start, .instr, .pc_in, .sp_in, .ps_in, .ea_in,
        .ea_is_reg, .reg_val_in, .busy, .done, .pc_out, .sp_out, .ps_out,
        .reg_wr, .reg_wr_data, .trace_trap, .illegal, .mem_req, .mem_we,
        .mem_byte, .mem_space, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
        .bus_abort, .bus_init, .continue_key, .halted, .resume, .console_data);
    task automatic stop_test();
        $display("Compares %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        n_resume += (resume === 1'b1);
        n_abort += (bus_abort === 1'b1);
        if (mem_req === 1'b1 && mem_ack === 1'b1) begin
            if (mem_we) begin
                wr_space = mem_space;
            end else begin
                rd_space = mem_space;
                rd_byte = mem_byte;
            end
        end
        if (cycles == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        cyc <= 1'b0;
    endtask
    task automatic run(input logic [15:0] op, pc, sp, ps, ea);
        @(posedge clk_sys);
        instr <= op;
        pc_in <= pc;
        sp_in <= sp;
        ps_in <= ps;
        ea_in <= ea;
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        do begin
            @(posedge clk_sys);
            trc = trace_trap;
            wr = reg_wr;
            wr_data = reg_wr_data;
        end while (done !== 1'b1 && halted !== 1'b1);
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            lag <= i[1:0];
            mem_m.mem[12 + 2 * i[1]] = 16'h1000 + i[15:0];
            mem_m.mem[13 + 2 * i[1]] = 16'h00e0 + i[15:0];
            run({8'h88 + 8'(i[1]), i[0] ? 8'hff : 8'h00}, 16'h0300 + i[15:0],
                16'h0100, 16'h300f, 16'h0000);
            chk(pc_out, 32'h1000 + i);
            chk(ps_out, 32'h00e0 + i);
            chk(sp_out, 32'h00fc);
            chk(rd_space, 32'h0);
            chk(mem_m.mem[127], 32'h300f);
            chk(mem_m.mem[126], 32'h0300 + i);
        end
        $display("Test call traps finished");
        for (int j = 0; j < 2; j++) begin
            mem_m.mem[64] = 16'h0456;
            mem_m.mem[65] = 16'h0019;
            run(j ? OP_RTT : OP_IRET, 16'h0200, 16'h0080, 16'h0000, 16'h0);
            chk(pc_out, 32'h0456);
            chk(ps_out, 32'h0019);
            chk(sp_out, 32'h0084);
            chk(trc, j ? 1'b0 : 1'b1);
        end
        $display("Test returns finished");
        mem_m.mem[32] = 16'h8000;
        run(16'h8d40, 16'h0200, 16'h0100, 16'h3001, 16'h0040);
        chk(mem_m.mem[127], 32'h8000);
        chk(ps_out, 32'h3009);
        chk(rd_space, 32'h3);
        chk(wr_space, 32'h0);
        chk(rd_byte, 1'b0);
        mem_m.mem[127] = 16'h0000;
        mem_m.mem[34] = 16'hffff;
        run(16'h0d80, 16'h0200, 16'h00fe, 16'h2002, 16'h0044);
        chk(mem_m.mem[34], 32'h0000);
        chk(sp_out, 32'h0100);
        chk(ps_out, 32'h2004);
        chk(rd_space, 32'h0);
        chk(wr_space, 32'h2);
        $display("Test previous space moves finished");
        ea_is_reg <= 1'b1;
        run(16'h8dc0, 16'h0200, 16'h0100, 16'h0081, 16'h0);
        chk(wr, 1'b1);
        chk(wr_data, 32'hff81);
        chk(ps_out, 32'h0089);
        reg_val_in <= 16'h00ff;
        run(16'h8d00, 16'h0200, 16'h0100, 16'hc000, 16'h0);
        chk(ps_out, 32'hc0ef);
        chk(illegal, 1'b0);
        chk(wr, 1'b0);
        ea_is_reg <= 1'b0;
        mem_m.mem[34] = 16'h001f;
        run(16'h8d00, 16'h0200, 16'h0100, 16'h0000, 16'h0044);
        chk(ps_out, 32'h000f);
        chk(rd_byte, 1'b1);
        run(16'h0001, 16'h0200, 16'h0100, 16'h0000, 16'h0);
        chk(illegal, 1'b1);
        $display("Test status byte moves finished");
        run(OP_STOP, 16'h0202, 16'h0100, 16'h0000, 16'h0);
        chk(halted, 1'b1);
        chk(console_data, 32'h0202);
        chk(bus_init, 1'b0);
        wb(1'b0, REG_STATUS, 32'h0);
        chk(rdat[ST_HALTED_BIT], 1'b1);
        chk(rdat[ST_BUSY_BIT], 1'b1);
        chk(n_abort, 32'h1);
        wb(1'b0, REG_CONSOLE, 32'h0);
        chk(rdat, 32'h0202);
        wb(1'b0, 4'hc, 32'h0);
        chk(rdat, 32'h0);
        n0 = n_resume;
        wb(1'b1, REG_CONTROL, 32'h1);
        while (n_resume == n0) @(posedge clk_sys);
        chk(pc_out, 32'h0202);
        run(OP_STOP, 16'h0404, 16'h0100, 16'h0000, 16'h0);
        n0 = n_resume;
        continue_key <= 1'b1;
        while (n_resume == n0) @(posedge clk_sys);
        continue_key <= 1'b0;
        @(posedge clk_sys);
        chk(pc_out, 32'h0404);
        chk(halted, 1'b0);
        chk(n_abort, 32'h2);
        $display("Test stop and continue finished");
        stop_test();
    end
endmodule
